/* verilog/fifo_sequence_list_scheduler.v */
// FIFO sequence list scheduler: walks the linked entry list once per frame.
// Assumes a frame strobe from the timing unit and same-clock HDLC/assigner logic.
//
// Contract
// - Processing starts at the first-FIFO selection: direction (0 = transmit) and number.
// - Channel and next-entry registers are addressed by list position in sequence mode.
// - Entries in any order and direction are followed exactly as linked.
// - Subchannel and mask at reset values pass whole bytes unchanged.
// - Per-FIFO settings are addressed by FIFO number and direction, not list position.
// - Channels not tied to line channels occupy no line resources.
// - Blocked channels carry no data but their configuration is still accepted.
// - Fill select zero gives flag byte 0x7e between HDLC frames.
// - Walk stops at an entry with end flag set or at list position 31, continues otherwise.
// - Whole list processed once per 125 us frame from position 0 upward.
// - Repeated FIFO bytes go to its channels in list order.
// - List position takes 0 to 31 and replaces FIFO select for channel registers.
`timescale 1ns/1ns
`include "seq_sched_map.vh"
module fifo_sequence_list_scheduler (
	input  wire                    i_clk_sys,
	input  wire                    i_reset_n,
	input  wire                    i_frame_strobe,
	input  wire                    i_queue_sequence_mode,
	input  wire                    i_first_fifo_dir,
	input  wire [`FIFO_NUM_W-1:0]  i_first_fifo_num,
	input  wire                    i_cfg_write,
	input  wire [1:0]              i_cfg_target,
	input  wire [`LIST_IDX_W-1:0]  i_list_position_select,
	input  wire [`FIFO_SEL_W-1:0]  i_fifo_select,
	input  wire [`FS_W-1:0]        i_cfg_data,
	input  wire [31:0]             i_line_tied,
	input  wire [31:0]             i_channel_blocked,
	input  wire [7:0]              i_tx_fifo_byte,
	input  wire                    i_tx_fifo_has_data,
	input  wire [7:0]              i_rx_chan_byte,
	output reg                     o_busy,
	output reg  [`LIST_IDX_W-1:0]  o_list_position,
	output reg  [`FIFO_SEL_W-1:0]  o_fifo_sel,
	output reg  [`CH_W-1:0]        o_internal_timeslot_channel,
	output reg                     o_tx_pop,
	output reg  [7:0]              o_tx_chan_byte,
	output reg                     o_tx_chan_valid,
	output reg                     o_rx_push,
	output reg  [7:0]              o_rx_fifo_byte,
	output reg                     o_line_claim,
	output reg                     o_frame_done
);
	// ----------------------------------------
	// Configuration storage
	// ----------------------------------------
	// Target codes for i_cfg_target
	localparam [1:0] T_FIFO = 2'h0;
	localparam [1:0] T_CHAN = 2'h1;
	localparam [1:0] T_LINK = 2'h2;
	localparam [1:0] T_SUBC = 2'h3;
	localparam       FIFOS  = 1 << `FIFO_SEL_W;

	reg [`FS_W-1:0]   fifo_set_q [0:FIFOS-1];
	reg [`CH_W-1:0]   chan_q     [0:`LIST_ENTRIES-1];
	reg [`LINK_W-1:0] link_q     [0:`LIST_ENTRIES-1];
	reg [7:0]         subch_q    [0:`LIST_ENTRIES-1];
	// Mask bytes have no write path here and keep their reset value
	reg [7:0]         mask_q     [0:`LIST_ENTRIES-1];
	genvar g;

	generate
		for (g = 0; g < `LIST_ENTRIES; g = g + 1) begin : g_entry
			always @(posedge i_clk_sys or negedge i_reset_n) begin
				if (!i_reset_n) begin
					fifo_set_q[g] <= `FS_RESET;
					chan_q[g]     <= `CH_RESET;
					link_q[g]     <= `LINK_RESET;
					subch_q[g]    <= `SUBCH_RESET;
					mask_q[g]     <= `MASK_RESET;
				end else if (i_cfg_write) begin
					// FIFO settings follow the FIFO select word
					if (i_cfg_target == T_FIFO && i_fifo_select == g) begin
						fifo_set_q[g] <= i_cfg_data;
					end
					// Channel-based registers follow list position in sequence mode
					if (i_queue_sequence_mode && i_list_position_select == g) begin
						if (i_cfg_target == T_CHAN) begin
							chan_q[g] <= i_cfg_data[`CH_W-1:0];
						end
						if (i_cfg_target == T_LINK) begin
							link_q[g] <= i_cfg_data[`LINK_W-1:0];
						end
						if (i_cfg_target == T_SUBC) begin
							subch_q[g] <= i_cfg_data[7:0];
						end
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Current entry decode
	// ----------------------------------------
	localparam [2:0] S_IDLE = 3'b001;
	localparam [2:0] S_WALK = 3'b010;
	localparam [2:0] S_DONE = 3'b100;

	reg [2:0]             state_q;
	reg [`FIFO_SEL_W-1:0] cur_fifo_q;
	reg [`LIST_IDX_W-1:0] pos_q;
	reg [7:0]             tx_byte;

	// Strobes seen while a walk is running are ignored
	wire                   start    = i_frame_strobe & i_queue_sequence_mode;
	wire [`FS_W-1:0]       cur_set  = fifo_set_q[cur_fifo_q];
	wire [`LINK_W-1:0]     cur_link = link_q[pos_q];
	wire [`CH_W-1:0]       cur_chan = chan_q[pos_q];
	wire                   cur_en   = |cur_set[`FS_ENABLE_MSB:`FS_ENABLE_LSB];
	wire                   cur_rx   = cur_fifo_q[`FIFO_SEL_W-1];
	wire                   cur_hdlc = ~cur_set[`FS_TRP_BIT];
	wire                   carry    = cur_en & ~i_channel_blocked[cur_chan];
	wire                   sub_def  = (subch_q[pos_q] == `SUBCH_RESET);
	wire                   mask_def = (mask_q[pos_q] == `MASK_RESET);
	wire                   subc_def = sub_def & mask_def;
	wire [7:0]             fill     = cur_set[`FS_IFF_BIT] ? `ONES_BYTE : `FLAG_BYTE;
	// Walk ends at the end flag or at the last storable entry
	wire                   last     = cur_link[`LINK_END_BIT] | (pos_q == `LIST_ENTRIES - 1);
	wire [`LIST_IDX_W-1:0] nxt_pos  = pos_q + 1'b1;
	wire [`FIFO_SEL_W-1:0] nxt_fifo = cur_link[`FIFO_SEL_W-1:0];
	wire [`CH_W-1:0]       nxt_chan = chan_q[nxt_pos];

	// Dry FIFO: fill select byte (flag or all ones) in HDLC mode, all ones in transparent mode
	always @* begin
		tx_byte = fill;
		if (i_tx_fifo_has_data) begin
			tx_byte = i_tx_fifo_byte;
		end else if (!cur_hdlc) begin
			tx_byte = `ONES_BYTE;
		end
	end

	// ----------------------------------------
	// Entry address outputs
	// ----------------------------------------
	// The address of an entry stands while its bytes are sampled, so the FIFO
	// and the channel assigner answer for the entry being processed
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_list_position             <= {`LIST_IDX_W{1'b0}};
			o_fifo_sel                  <= {`FIFO_SEL_W{1'b0}};
			o_internal_timeslot_channel <= {`CH_W{1'b0}};
		end else if (state_q == S_IDLE && start) begin
			o_list_position             <= {`LIST_IDX_W{1'b0}};
			o_fifo_sel                  <= {i_first_fifo_dir, i_first_fifo_num};
			o_internal_timeslot_channel <= chan_q[0];
		end else if (state_q == S_WALK && !last) begin
			o_list_position             <= nxt_pos;
			o_fifo_sel                  <= nxt_fifo;
			o_internal_timeslot_channel <= nxt_chan;
		end
	end

	// ----------------------------------------
	// List walker
	// ----------------------------------------
	always @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q         <= S_IDLE;
			cur_fifo_q      <= {`FIFO_SEL_W{1'b0}};
			pos_q           <= {`LIST_IDX_W{1'b0}};
			o_busy          <= 1'b0;
			o_tx_pop        <= 1'b0;
			o_tx_chan_byte  <= 8'h00;
			o_tx_chan_valid <= 1'b0;
			o_rx_push       <= 1'b0;
			o_rx_fifo_byte  <= 8'h00;
			o_line_claim    <= 1'b0;
			o_frame_done    <= 1'b0;
		end else begin
			o_tx_pop        <= 1'b0;
			o_tx_chan_valid <= 1'b0;
			o_rx_push       <= 1'b0;
			o_line_claim    <= 1'b0;
			o_frame_done    <= 1'b0;
			case (state_q)
				S_IDLE: begin
					o_busy <= 1'b0;
					if (start) begin
						cur_fifo_q <= {i_first_fifo_dir, i_first_fifo_num};
						pos_q      <= {`LIST_IDX_W{1'b0}};
						state_q    <= S_WALK;
						o_busy     <= 1'b1;
					end
				end
				S_WALK: begin
					// One byte per entry, in list order, so repeats interleave
					if (carry && subc_def) begin
						o_line_claim <= i_line_tied[cur_chan];
						if (cur_rx) begin
							o_rx_push      <= 1'b1;
							o_rx_fifo_byte <= i_rx_chan_byte;
						end else begin
							// Only a real FIFO byte is popped; fill leaves the FIFO alone
							o_tx_pop        <= i_tx_fifo_has_data;
							o_tx_chan_valid <= 1'b1;
							o_tx_chan_byte  <= tx_byte;
						end
					end
					if (last) begin
						state_q      <= S_DONE;
						o_frame_done <= 1'b1;
					end else begin
						pos_q      <= nxt_pos;
						cur_fifo_q <= nxt_fifo;
					end
				end
				S_DONE: begin
					// One quiet cycle before a new strobe is taken
					o_busy  <= 1'b0;
					state_q <= S_IDLE;
				end
				default: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end
endmodule

/* verilog/seq_sched_map.vh */
// Constants for the FIFO sequence list scheduler.
// Assumes inclusion by the scheduler module only.
`ifndef SEQ_SCHED_MAP_VH
`define SEQ_SCHED_MAP_VH
// ----------------------------------------
// List and FIFO geometry
// ----------------------------------------
`define LIST_ENTRIES      32
`define LIST_IDX_W        5
`define FIFO_NUM_W        4
`define FIFO_SEL_W        5
`define CHAN_NUM_W        4
`define DIR_TX            1'b0
`define DIR_RX            1'b1
// ----------------------------------------
// Per-FIFO setting fields (setting word layout)
// ----------------------------------------
`define FS_W              9
`define FS_ENABLE_LSB     0
`define FS_ENABLE_MSB     2
`define FS_IFF_BIT        3
`define FS_TRP_BIT        4
`define FS_REV_BIT        5
`define FS_FLOW_LSB       6
`define FS_FLOW_MSB       8
`define FS_RESET          9'h000
// ----------------------------------------
// List entry fields
// ----------------------------------------
`define CH_W              5
`define LINK_W            6
`define LINK_END_BIT      5
`define CH_RESET          5'h00
`define LINK_RESET        6'h20
`define SUBCH_RESET       8'h00
`define MASK_RESET        8'h00
// ----------------------------------------
// Bytes and timing
// ----------------------------------------
`define FLAG_BYTE         8'h7e
`define ONES_BYTE         8'hff
`define FRAME_NS          125000
`define CLK_NS            10
`define FRAME_CYCLES      (`FRAME_NS / `CLK_NS)
`endif

/* tb/chan_assigner_model.sv */
// Channel assigner model: offers the receive byte of the entry channel.
// Assumes the byte is sampled by the scheduler on its own clock.
`timescale 1ns/1ns
module chan_assigner_model (
	input  wire [4:0] i_chan,
	output wire [7:0] o_rx_byte
);
	// Each channel answers with its own number, so a wrong channel shows
	assign o_rx_byte = {3'b010, i_chan};
endmodule

/* tb/sched_assertions.sv */
// Checker for the sequence list scheduler outputs.
// Assumes a bind onto the scheduler top module.
`timescale 1ns/1ns
module sched_assertions (
	input wire       i_clk_sys,
	input wire       i_reset_n,
	input wire       i_frame_strobe,
	input wire       i_queue_sequence_mode,
	input wire       o_busy,
	input wire [4:0] o_list_position,
	input wire       o_tx_pop,
	input wire       o_tx_chan_valid,
	input wire       o_rx_push,
	input wire       o_line_claim,
	input wire       o_frame_done
);
	wire start = i_frame_strobe & i_queue_sequence_mode;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_reset_n);
	pop_has_byte_a: assert property (o_tx_pop |-> o_tx_chan_valid && o_busy)
		else $error("pop without byte");
	one_direction_a: assert property (!(o_tx_chan_valid && o_rx_push))
		else $error("both directions at once");
	done_to_idle_a: assert property (o_frame_done |=> !o_busy && !o_frame_done)
		else $error("still busy after done");
	start_cause_a: assert property ($rose(o_busy) |-> $past(start) || $past(start, 2))
		else $error("walk without strobe");
	list_bounded_a: assert property ($rose(o_busy) |-> ##[1:40] o_frame_done)
		else $error("walk never ends");
	pos_ascend_a: assert property (o_busy && $changed(o_list_position) |->
		o_list_position == $past(o_list_position) + 5'h01 || o_list_position == 5'h00)
		else $error("position skipped");
	claim_with_data_a: assert property (o_line_claim |-> o_tx_chan_valid || o_rx_push)
		else $error("claim without data");
	idle_quiet_a: assert property (!o_busy |-> !o_tx_chan_valid && !o_rx_push)
		else $error("data while idle");
endmodule

/* tb/fifo_sequence_list_scheduler_test.sv */
// Testbench: programs a four entry list and checks the walk of each frame.
// Assumes the scheduler, checker and channel model are compiled first.
`timescale 1ns/1ns
module fifo_sequence_list_scheduler_test;
	reg         clk = 1'b0, rst_n = 1'b0, strobe = 1'b0, mode = 1'b1, wr = 1'b0, has = 1'b1, ffd = 1'b0;
	reg  [1:0]  tgt = 2'h0;
	reg  [4:0]  pos = 5'h00, sel = 5'h00;
	reg  [8:0]  dat = 9'h000;
	reg  [31:0] tied = 32'h0004_0000, blk = 32'h0;
	reg  [7:0]  popped = 8'h80;
	reg  [35:0] chans = {9'h004, 9'h003, 9'h012, 9'h002}, links = {9'h020, 9'h005, 9'h00c, 9'h01c};
	wire [7:0]  rxb, txb, rxf;
	wire [4:0]  lpos, fsel, ch;
	wire        busy, pop, tv, push, claim, done;
	reg  [23:0] exp_q[$];
	reg  [14:0] prev;
	integer     mismatches = 0, n_compared = 0, k, claims, dones;
	fifo_sequence_list_scheduler i_dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_frame_strobe(strobe),
		.i_queue_sequence_mode(mode), .i_first_fifo_dir(ffd), .i_first_fifo_num(4'hc), .i_cfg_write(wr),
		.i_cfg_target(tgt), .i_list_position_select(pos), .i_fifo_select(sel), .i_cfg_data(dat),
		.i_line_tied(tied), .i_channel_blocked(blk), .i_tx_fifo_byte(popped), .i_tx_fifo_has_data(has),
		.i_rx_chan_byte(rxb), .o_busy(busy), .o_list_position(lpos), .o_fifo_sel(fsel),
		.o_internal_timeslot_channel(ch), .o_tx_pop(pop), .o_tx_chan_byte(txb), .o_tx_chan_valid(tv),
		.o_rx_push(push), .o_rx_fifo_byte(rxf), .o_line_claim(claim), .o_frame_done(done));
	chan_assigner_model i_chan (.i_chan(ch), .o_rx_byte(rxb));
	always #5 clk = ~clk;
	// FIFO model: next byte appears once the current one is consumed
	always @(posedge clk) if (pop === 1'b1) popped <= popped + 8'h01;
	task conclude;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0) $display("All tests passed");
			else $display("Some tests failed");
			$finish;
		end
	endtask
	task check(input [23:0] e, input [23:0] s);
		begin
			n_compared = n_compared + 1;
			if (e !== s) begin
				mismatches = mismatches + 1;
				$display("wrong value entry expected %h seen %h", e, s);
			end
		end
	endtask
	task cfg(input [1:0] t, input [4:0] p, input [4:0] s, input [8:0] d);
		begin
			@(negedge clk);
			{wr, tgt, pos, sel, dat} = {1'b1, t, p, s, d};
			@(negedge clk);
			wr = 1'b0;
		end
	endtask
	// -------------------------------------
	// One frame: every transfer against the queue
	// -------------------------------------
	task walk(input integer n_claim);
		begin
			@(negedge clk);
			strobe = 1'b1;
			@(negedge clk);
			strobe = 1'b0;
			prev = {lpos, fsel, ch};
			claims = 0;
			dones = 0;
			repeat (50) begin
				@(negedge clk);
				claims = claims + (claim === 1'b1);
				dones = dones + (done === 1'b1);
				// Transfer outputs follow the entry address by one cycle
				if ((tv | push) === 1'b1)
					check(exp_q.size() ? exp_q.pop_front() : 24'h0, {prev, push, push ? rxf : txb});
				prev = {lpos, fsel, ch};
			end
			check(0, exp_q.size());
			check(n_claim, claims);
			check(mode, dones);
		end
	endtask
	task t_order;
		begin
			exp_q = '{{5'h00, 5'h0c, 5'h02, 1'b0, 8'h80}, {5'h01, 5'h1c, 5'h12, 1'b1, 8'h52},
				{5'h02, 5'h0c, 5'h03, 1'b0, 8'h81}};
			walk(1);
		end
	endtask
	task t_fill;
		begin
			has = 1'b0;
			exp_q = '{{5'h00, 5'h0c, 5'h02, 1'b0, 8'h7e}, {5'h01, 5'h1c, 5'h12, 1'b1, 8'h52},
				{5'h02, 5'h0c, 5'h03, 1'b0, 8'h7e}};
			walk(1);
			cfg(2'h0, 5'h00, 5'h0c, 9'h00f);
			exp_q = '{{5'h00, 5'h0c, 5'h02, 1'b0, 8'hff}, {5'h01, 5'h1c, 5'h12, 1'b1, 8'h52},
				{5'h02, 5'h0c, 5'h03, 1'b0, 8'hff}};
			walk(1);
			cfg(2'h0, 5'h00, 5'h0c, 9'h007);
			check(8'h82, popped);
			has = 1'b1;
		end
	endtask
	task t_blocked;
		begin
			blk = 32'h0000_0004;
			exp_q = '{{5'h01, 5'h1c, 5'h12, 1'b1, 8'h52}, {5'h02, 5'h0c, 5'h03, 1'b0, 8'h82}};
			walk(1);
			blk = 32'h0;
		end
	endtask
	task t_mode_off;
		begin
			mode = 1'b0;
			cfg(2'h1, 5'h00, 5'h00, 9'h01f);
			walk(0);
			mode = 1'b1;
		end
	endtask
	// -------------------------------------
	// First FIFO in receive direction; refused channel write must not show
	// -------------------------------------
	task t_first_rx;
		begin
			ffd = 1'b1;
			exp_q = '{{5'h00, 5'h1c, 5'h02, 1'b1, 8'h42}, {5'h01, 5'h1c, 5'h12, 1'b1, 8'h52},
				{5'h02, 5'h0c, 5'h03, 1'b0, 8'h83}};
			walk(1);
			ffd = 1'b0;
		end
	endtask
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk);
		rst_n = 1'b1;
		cfg(2'h0, 5'h00, 5'h0c, 9'h007);
		cfg(2'h0, 5'h00, 5'h1c, 9'h007);
		for (k = 0; k < 4; k = k + 1) begin
			cfg(2'h1, k, 5'h00, chans[k*9 +: 9]);
			cfg(2'h2, k, 5'h00, links[k*9 +: 9]);
		end
		t_order;
		t_fill;
		t_blocked;
		t_mode_off;
		t_first_rx;
		conclude;
	end
	initial begin
		#20000;
		mismatches = mismatches + 1;
		conclude;
	end
endmodule
bind fifo_sequence_list_scheduler sched_assertions i_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
	.i_frame_strobe(i_frame_strobe), .i_queue_sequence_mode(i_queue_sequence_mode), .o_busy(o_busy),
	.o_list_position(o_list_position), .o_tx_pop(o_tx_pop), .o_tx_chan_valid(o_tx_chan_valid),
	.o_rx_push(o_rx_push), .o_line_claim(o_line_claim), .o_frame_done(o_frame_done));
